// >>> verilog/csw_alu_core.sv
// Byte datapath: accumulator, aux operand, status word, bit processor.
// Assumes the sequencer issues one operation per valid cycle and owns memory.
`timescale 1ns/10ps
`default_nettype none
module csw_alu_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic opValid,
  input wire csw_pkg::csw_op_t opCode,
  input wire logic [7:0] opData,
  input wire logic [2:0] opBit,
  output logic [7:0] opResult,
  output logic opTaken,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  input wire logic [7:0] bitAddr,
  input wire logic bitWrEn,
  input wire logic bitWrData,
  output logic bitRdData,
  output logic extWrEn,
  output logic extRdEn,
  output logic [7:0] extAddr,
  output logic [7:0] extWrData,
  input wire logic [7:0] extRdData,
  output logic [7:0] mainOperand,
  output logic [7:0] auxOperand,
  output logic [7:0] statusWord,
  output logic [4:0] bankBase
);
  csw_pkg::csw_state_t state_reg;
  csw_pkg::csw_state_t state_next;
  logic [15:0] product;
  logic [7:0] quotient;
  logic [7:0] remainder;
  logic divZero;
  csw_pkg::csw_sel_t byteSel;
  csw_pkg::csw_sel_t bitSel;

  // Owner of an aligned group of eight addresses
  function automatic csw_pkg::csw_sel_t regSelect(input logic [4:0] blk);
    if (blk == csw_pkg::ADDR_MAIN[7:3])
      return csw_pkg::SEL_MAIN;
    else if (blk == csw_pkg::ADDR_AUX[7:3])
      return csw_pkg::SEL_AUX;
    else if (blk == csw_pkg::ADDR_STATUS[7:3])
      return csw_pkg::SEL_STATUS;
    else
      return csw_pkg::SEL_NONE;
  endfunction : regSelect

  // Add with carry in; returns {carry, nibble carry, wrap, sum}
  function automatic logic [10:0] addFlags(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
    logic [8:0] sum;
    logic [4:0] nib;
    logic wrap;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    wrap = (a[7] == b[7]) && (sum[7] != a[7]);
    return {sum[8], nib[4], wrap, sum[7:0]};
  endfunction : addFlags

  // Subtract with borrow in; returns {borrow, nibble borrow, wrap, difference}
  function automatic logic [10:0] subFlags(input logic [7:0] a, input logic [7:0] b,
                                           input logic bin);
    logic [8:0] diff;
    logic [4:0] nib;
    logic wrap;
    diff = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    wrap = (a[7] != b[7]) && (diff[7] != a[7]);
    return {diff[8], nib[4], wrap, diff[7:0]};
  endfunction : subFlags

  // Replace one bit of a byte
  function automatic logic [7:0] putBit(input logic [7:0] v, input logic [2:0] idx,
                                        input logic b);
    logic [7:0] r;
    r = v;
    r[idx] = b;
    return r;
  endfunction : putBit

  // Multiply and divide share the accumulator and aux register
  csw_muldiv #(
    .W(csw_pkg::DATA_W)
  ) u_muldiv (
    .lhs(state_reg.mainOperand),
    .rhs(state_reg.auxOperand),
    .product(product),
    .quotient(quotient),
    .remainder(remainder),
    .divZero(divZero)
  );

  // Byte access needs an aligned address; bit access uses the low three bits
  assign byteSel = (sfrAddr[2:0] == 3'h0) ? regSelect(sfrAddr[7:3]) : csw_pkg::SEL_NONE;
  assign bitSel = regSelect(bitAddr[7:3]);

  // Foreign addresses are handed straight to external devices
  assign extWrEn = sfrWrEn && (byteSel == csw_pkg::SEL_NONE);
  assign extRdEn = sfrRdEn && (byteSel == csw_pkg::SEL_NONE);
  assign extAddr = sfrAddr;
  assign extWrData = sfrWrData;

  // Next state: register writes first, then the operation, then parity
  always_comb
  begin
    logic [10:0] ar;
    logic [7:0] a;
    logic cy;
    logic opb;
    logic [7:0] cur;
    state_next = state_reg;
    ar = 11'h000;
    a = state_reg.mainOperand;
    cy = state_reg.statusWord[csw_pkg::BIT_CARRY];
    opb = opData[opBit];
    cur = 8'h00;
    state_next.taken = 1'b0;
    // Reads sample the value before this cycle's writes
    if (sfrRdEn)
    begin
      case (byteSel)
        csw_pkg::SEL_MAIN: state_next.rdData = state_reg.mainOperand;
        csw_pkg::SEL_AUX: state_next.rdData = state_reg.auxOperand;
        csw_pkg::SEL_STATUS: state_next.rdData = state_reg.statusWord;
        default: state_next.rdData = extRdData;
      endcase
    end
    case (bitSel)
      csw_pkg::SEL_MAIN: cur = state_reg.mainOperand;
      csw_pkg::SEL_AUX: cur = state_reg.auxOperand;
      csw_pkg::SEL_STATUS: cur = state_reg.statusWord;
      default: cur = 8'h00;
    endcase
    state_next.rdBit = cur[bitAddr[2:0]];
    // Byte writes; the user flags and bank select are plain storage
    if (sfrWrEn)
    begin
      case (byteSel)
        csw_pkg::SEL_MAIN: state_next.mainOperand = sfrWrData;
        csw_pkg::SEL_AUX: state_next.auxOperand = sfrWrData;
        csw_pkg::SEL_STATUS: state_next.statusWord = sfrWrData;
        default: state_next.statusWord = state_next.statusWord;
      endcase
    end
    // Single-bit writes to the three owned registers
    if (bitWrEn)
    begin
      case (bitSel)
        csw_pkg::SEL_MAIN:
          state_next.mainOperand = putBit(state_next.mainOperand, bitAddr[2:0], bitWrData);
        csw_pkg::SEL_AUX:
          state_next.auxOperand = putBit(state_next.auxOperand, bitAddr[2:0], bitWrData);
        csw_pkg::SEL_STATUS:
          state_next.statusWord = putBit(state_next.statusWord, bitAddr[2:0], bitWrData);
        default: state_next.rdBit = state_next.rdBit;
      endcase
    end
    // Operation wins over a register write landing in the same cycle
    if (opValid)
    begin
      case (opCode)
        csw_pkg::OP_ADD, csw_pkg::OP_ADDC:
        begin
          ar = addFlags(a, opData, (opCode == csw_pkg::OP_ADDC) && cy);
          state_next.mainOperand = ar[7:0];
          state_next.statusWord[csw_pkg::BIT_CARRY] = ar[10];
          state_next.statusWord[csw_pkg::BIT_NIBBLE] = ar[9];
          state_next.statusWord[csw_pkg::BIT_WRAP] = ar[8];
        end
        csw_pkg::OP_SUBB:
        begin
          ar = subFlags(a, opData, cy);
          state_next.mainOperand = ar[7:0];
          state_next.statusWord[csw_pkg::BIT_CARRY] = ar[10];
          state_next.statusWord[csw_pkg::BIT_NIBBLE] = ar[9];
          state_next.statusWord[csw_pkg::BIT_WRAP] = ar[8];
        end
        csw_pkg::OP_CMP:
        begin
          // Compare leaves the accumulator and only moves carry
          ar = subFlags(a, opData, 1'b0);
          state_next.statusWord[csw_pkg::BIT_CARRY] = ar[10];
          state_next.taken = (a != opData);
        end
        csw_pkg::OP_INC: state_next.mainOperand = a + 8'h01;
        csw_pkg::OP_DEC: state_next.mainOperand = a - 8'h01;
        csw_pkg::OP_MUL:
        begin
          state_next.mainOperand = product[7:0];
          state_next.auxOperand = product[15:8];
          state_next.statusWord[csw_pkg::BIT_CARRY] = 1'b0;
          state_next.statusWord[csw_pkg::BIT_WRAP] = (product[15:8] != 8'h00);
        end
        csw_pkg::OP_DIV:
        begin
          // Zero divisor keeps both operands and raises the wrap flag
          if (!divZero)
          begin
            state_next.mainOperand = quotient;
            state_next.auxOperand = remainder;
          end
          state_next.statusWord[csw_pkg::BIT_CARRY] = 1'b0;
          state_next.statusWord[csw_pkg::BIT_WRAP] = divZero;
        end
        csw_pkg::OP_DA:
        begin
          // Decimal adjust may set carry but never clears it
          ar = {3'b000, a};
          if ((a[3:0] > csw_pkg::BCD_MAX) || state_reg.statusWord[csw_pkg::BIT_NIBBLE])
            ar = addFlags(a, csw_pkg::BCD_FIX_LO, 1'b0);
          cy = cy || ar[10];
          if ((ar[7:4] > csw_pkg::BCD_MAX) || cy)
          begin
            ar = addFlags(ar[7:0], csw_pkg::BCD_FIX_HI, 1'b0);
            cy = cy || ar[10];
          end
          state_next.mainOperand = ar[7:0];
          state_next.statusWord[csw_pkg::BIT_CARRY] = cy;
        end
        csw_pkg::OP_ANL: state_next.mainOperand = a & opData;
        csw_pkg::OP_ORL: state_next.mainOperand = a | opData;
        csw_pkg::OP_XRL: state_next.mainOperand = a ^ opData;
        csw_pkg::OP_CPLA: state_next.mainOperand = ~a;
        csw_pkg::OP_CLRA: state_next.mainOperand = 8'h00;
        csw_pkg::OP_RL: state_next.mainOperand = {a[6:0], a[7]};
        csw_pkg::OP_RR: state_next.mainOperand = {a[0], a[7:1]};
        csw_pkg::OP_RLC:
        begin
          state_next.mainOperand = {a[6:0], cy};
          state_next.statusWord[csw_pkg::BIT_CARRY] = a[7];
        end
        csw_pkg::OP_RRC:
        begin
          state_next.mainOperand = {cy, a[7:1]};
          state_next.statusWord[csw_pkg::BIT_CARRY] = a[0];
        end
        csw_pkg::OP_SWAP: state_next.mainOperand = {a[3:0], a[7:4]};
        csw_pkg::OP_SETBC: state_next.statusWord[csw_pkg::BIT_CARRY] = 1'b1;
        csw_pkg::OP_CLRC: state_next.statusWord[csw_pkg::BIT_CARRY] = 1'b0;
        csw_pkg::OP_CPLC: state_next.statusWord[csw_pkg::BIT_CARRY] = !cy;
        csw_pkg::OP_SETBIT: state_next.result = putBit(opData, opBit, 1'b1);
        csw_pkg::OP_CLRBIT: state_next.result = putBit(opData, opBit, 1'b0);
        csw_pkg::OP_CPLBIT: state_next.result = putBit(opData, opBit, !opb);
        csw_pkg::OP_JNB:
        begin
          state_next.taken = !opb;
          state_next.result = opData;
        end
        csw_pkg::OP_JBC:
        begin
          state_next.taken = opb;
          state_next.result = putBit(opData, opBit, 1'b0);
        end
        csw_pkg::OP_MOVCB: state_next.statusWord[csw_pkg::BIT_CARRY] = opb;
        csw_pkg::OP_MOVBC: state_next.result = putBit(opData, opBit, cy);
        csw_pkg::OP_ANLCB: state_next.statusWord[csw_pkg::BIT_CARRY] = cy && opb;
        csw_pkg::OP_ORLCB: state_next.statusWord[csw_pkg::BIT_CARRY] = cy || opb;
        default: state_next.taken = 1'b0;
      endcase
      // Byte results also report the new accumulator for writeback
      if (opCode <= csw_pkg::OP_SWAP)
        state_next.result = state_next.mainOperand;
    end
    // Parity is hardware-owned; software writes to it do not stick
    state_next.statusWord[csw_pkg::BIT_PARITY] = ^state_next.mainOperand;
  end

  // Single state register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (rst)
      state_reg <= csw_pkg::STATE_RESET;
    else
      state_reg <= state_next;
  end

  // Register-driven outputs
  assign mainOperand = state_reg.mainOperand;
  assign auxOperand = state_reg.auxOperand;
  assign statusWord = state_reg.statusWord;
  assign sfrRdData = state_reg.rdData;
  assign bitRdData = state_reg.rdBit;
  assign opResult = state_reg.result;
  assign opTaken = state_reg.taken;
  // Bank window base: bank number times eight
  assign bankBase = {state_reg.statusWord[csw_pkg::BIT_BANK_HI:csw_pkg::BIT_BANK_LO],
                     3'b000};
endmodule : csw_alu_core
`default_nettype wire

// >>> verilog/csw_pkg.sv
// Constants and types for the byte datapath with accumulator, aux operand and status word.
// Assumes one 100 MHz clock and a synchronous active-high reset in every user.
package csw_pkg;
  localparam int DATA_W = 8;
  // Special register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'hd0;
  localparam logic [7:0] ADDR_MAIN = 8'he0;
  localparam logic [7:0] ADDR_AUX = 8'hf0;
  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MAIN = 8'h00;
  localparam logic [7:0] RST_AUX = 8'h00;
  // Status word field positions
  localparam int BIT_CARRY = 7;
  localparam int BIT_NIBBLE = 6;
  localparam int BIT_USER0 = 5;
  localparam int BIT_BANK_HI = 4;
  localparam int BIT_BANK_LO = 3;
  localparam int BIT_WRAP = 2;
  localparam int BIT_USER1 = 1;
  localparam int BIT_PARITY = 0;
  // Register window of eight bytes per bank
  localparam int BANK_SHIFT = 3;
  // Decimal adjust thresholds and corrections
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] BCD_FIX_LO = 8'h06;
  localparam logic [7:0] BCD_FIX_HI = 8'h60;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADDC = 5'h02, OP_SUBB = 5'h03,
    OP_INC = 5'h04, OP_DEC = 5'h05, OP_MUL = 5'h06, OP_DIV = 5'h07,
    OP_DA = 5'h08, OP_CMP = 5'h09, OP_ANL = 5'h0a, OP_ORL = 5'h0b,
    OP_XRL = 5'h0c, OP_CPLA = 5'h0d, OP_CLRA = 5'h0e, OP_RL = 5'h0f,
    OP_RLC = 5'h10, OP_RR = 5'h11, OP_RRC = 5'h12, OP_SWAP = 5'h13,
    OP_SETBC = 5'h14, OP_CLRC = 5'h15, OP_CPLC = 5'h16, OP_SETBIT = 5'h17,
    OP_CLRBIT = 5'h18, OP_CPLBIT = 5'h19, OP_JNB = 5'h1a, OP_JBC = 5'h1b,
    OP_MOVCB = 5'h1c, OP_MOVBC = 5'h1d, OP_ANLCB = 5'h1e, OP_ORLCB = 5'h1f
  } csw_op_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_MAIN = 2'h1,
    SEL_AUX = 2'h2,
    SEL_STATUS = 2'h3
  } csw_sel_t;

  typedef struct packed {
    logic [7:0] mainOperand;
    logic [7:0] auxOperand;
    logic [7:0] statusWord;
    logic [7:0] rdData;
    logic rdBit;
    logic [7:0] result;
    logic taken;
  } csw_state_t;

  localparam csw_state_t STATE_RESET = '{
    mainOperand: RST_MAIN,
    auxOperand: RST_AUX,
    statusWord: RST_STATUS,
    rdData: 8'h00,
    rdBit: 1'b0,
    result: 8'h00,
    taken: 1'b0
  };
endpackage : csw_pkg

// >>> verilog/csw_muldiv.sv
// Unsigned 8x8 multiplier and 8/8 divider, purely combinational.
// Assumes the caller registers the results and handles divide by zero.
`timescale 1ns/10ps
`default_nettype none
module csw_muldiv #(
  parameter int W = 8
) (
  input wire logic [W-1:0] lhs,
  input wire logic [W-1:0] rhs,
  output logic [2*W-1:0] product,
  output logic [W-1:0] quotient,
  output logic [W-1:0] remainder,
  output logic divZero
);
  // Divider guarded so a zero divisor never reaches the operator
  always_comb
  begin
    product = lhs * rhs;
    divZero = (rhs == '0);
    quotient = divZero ? '0 : lhs / rhs;
    remainder = divZero ? '0 : lhs % rhs;
  end
endmodule : csw_muldiv
`default_nettype wire

// >>> tb/csw_alu_core_sva.sv
// Checker for csw_alu_core: register reads, status layout, key operations.
// Assumes one clock and a synchronous active-high reset; bound at the file foot.
`timescale 1ns/10ps
`default_nettype none
module csw_alu_core_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic opValid,
  input wire csw_pkg::csw_op_t opCode,
  input wire logic [7:0] opData,
  input wire logic opTaken,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic extWrEn,
  input wire logic [7:0] extAddr,
  input wire logic [7:0] extWrData,
  input wire logic [7:0] extRdData,
  input wire logic [7:0] mainOperand,
  input wire logic [7:0] auxOperand,
  input wire logic [7:0] statusWord,
  input wire logic [4:0] bankBase
);
  logic ownAddr;
  // Only the three datapath registers stay off the external port
  assign ownAddr = sfrAddr inside {csw_pkg::ADDR_STATUS, csw_pkg::ADDR_MAIN, csw_pkg::ADDR_AUX};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Issue steps of the multi-cycle checks
  sequence sCmpIssue;
    opValid && opCode == csw_pkg::OP_CMP;
  endsequence
  sequence sDivZero;
    opValid && opCode == csw_pkg::OP_DIV && auxOperand == 8'h00;
  endsequence
  sequence sAuxWrite;
    sfrWrEn && sfrAddr == csw_pkg::ADDR_AUX && !opValid;
  endsequence
  sequence sMainRead;
    sfrRdEn && sfrAddr == csw_pkg::ADDR_MAIN;
  endsequence
  a_parity_tracks_main: assert property (statusWord[0] == ^mainOperand)
    else $error("parity flag differs from accumulator xor");
  a_bank_base_map: assert property (bankBase == {statusWord[4:3], 3'h0})
    else $error("bank base does not follow bank select");
  a_reset_clears_all: assert property ($fell(rst) |->
    {mainOperand, auxOperand, statusWord} == 24'h0)
    else $error("registers not cleared by reset");
  a_main_read_back: assert property (sMainRead |=> sfrRdData == $past(mainOperand))
    else $error("accumulator read returned wrong byte");
  a_aux_write_lands: assert property (sAuxWrite |=> auxOperand == $past(sfrWrData))
    else $error("aux register write lost");
  a_ext_write_pass: assert property (sfrWrEn && !ownAddr |->
    extWrEn && extAddr == sfrAddr && extWrData == sfrWrData)
    else $error("foreign write not passed outward");
  a_own_write_local: assert property (sfrWrEn && ownAddr |-> !extWrEn)
    else $error("local write leaked outward");
  a_ext_read_data: assert property (sfrRdEn && !ownAddr |=> sfrRdData == $past(extRdData))
    else $error("foreign read data not returned");
  a_cmp_flags: assert property (sCmpIssue |=>
    opTaken == ($past(mainOperand) != $past(opData)) &&
    statusWord[7] == ($past(mainOperand) < $past(opData)))
    else $error("compare result or carry wrong");
  a_div_zero_keeps: assert property (sDivZero |=>
    $stable(mainOperand) && $stable(auxOperand) && statusWord[2] && !statusWord[7])
    else $error("divide by zero handling wrong");
  a_idle_no_taken: assert property (!opValid |=> !opTaken)
    else $error("taken flag without an operation");
endmodule : csw_alu_core_sva
bind csw_alu_core csw_alu_core_sva u_checker (.clk, .rst, .opValid, .opCode, .opData, .opTaken,
  .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData, .extWrEn, .extAddr, .extWrData,
  .extRdData, .mainOperand, .auxOperand, .statusWord, .bankBase);
`default_nettype wire

// >>> tb/cpu_alu_status_word_test.sv
// Self-checking bench for csw_alu_core with a bench reference of every operation.
// Assumes csw_pkg, the design and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module cpu_alu_status_word_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic opValid = 1'b0;
  csw_pkg::csw_op_t opCode = csw_pkg::OP_NOP;
  logic [7:0] opData = 8'h00;
  logic [2:0] opBit = 3'h0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrRdEn = 1'b0;
  logic [7:0] bitAddr = 8'h00;
  logic bitWrEn = 1'b0;
  logic bitWrData = 1'b0;
  logic [7:0] extRdData = 8'h00;
  logic [7:0] opResult, sfrRdData, extAddr, extWrData, mainOperand, auxOperand, statusWord;
  logic opTaken, bitRdData, extWrEn, extRdEn;
  logic [4:0] bankBase;
  logic [7:0] seed = 8'h54;
  logic [7:0] eMain, eAux, eRes, v, w;
  logic eCar, eTk, eResV;
  int errorCnt = 0;
  int cmpCount = 0;
  csw_pkg::csw_op_t op;
  csw_alu_core DUT (.clk, .rst, .opValid, .opCode, .opData, .opBit, .opResult, .opTaken,
    .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData, .bitAddr, .bitWrEn, .bitWrData,
    .bitRdData, .extWrEn, .extRdEn, .extAddr, .extWrData, .extRdData, .mainOperand,
    .auxOperand, .statusWord, .bankBase);
  // Free-running 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Shift register source; taps give the full 255-state cycle
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : rnd
  // Reference of one operation on the bench copies; overflow and nibble carry not kept
  function automatic void model(csw_pkg::csw_op_t c, logic [7:0] d, logic [2:0] k);
    logic [8:0] t;
    logic bt;
    bt = d[k];
    eTk = 1'b0;
    eRes = d;
    eResV = (c != csw_pkg::OP_NOP && c <= csw_pkg::OP_SWAP) || c inside {csw_pkg::OP_SETBIT,
      csw_pkg::OP_CLRBIT, csw_pkg::OP_CPLBIT, csw_pkg::OP_JBC, csw_pkg::OP_MOVBC};
    case (c)
      csw_pkg::OP_ADD: {eCar, eMain} = eMain + d;
      csw_pkg::OP_ADDC: {eCar, eMain} = eMain + d + eCar;
      csw_pkg::OP_SUBB: {eCar, eMain} = eMain - d - eCar;
      csw_pkg::OP_INC: eMain = eMain + 8'h01;
      csw_pkg::OP_DEC: eMain = eMain - 8'h01;
      csw_pkg::OP_MUL: {eCar, eAux, eMain} = eMain * eAux;
      csw_pkg::OP_DIV: {eCar, eMain, eAux} = (eAux != 8'h00) ?
        {1'b0, eMain / eAux, eMain % eAux} : {1'b0, eMain, eAux};
      csw_pkg::OP_DA:
      begin
        t = {1'b0, eMain} + ((eMain[3:0] > 4'h9) ? 9'h006 : 9'h000);
        eCar = eCar | t[8];
        t = {1'b0, t[7:0]} + ((t[7:4] > 4'h9 || eCar) ? 9'h060 : 9'h000);
        {eCar, eMain} = {eCar | t[8], t[7:0]};
      end
      csw_pkg::OP_CMP: {eTk, eCar} = {eMain != d, eMain < d};
      csw_pkg::OP_ANL: eMain = eMain & d;
      csw_pkg::OP_ORL: eMain = eMain | d;
      csw_pkg::OP_XRL: eMain = eMain ^ d;
      csw_pkg::OP_CPLA: eMain = ~eMain;
      csw_pkg::OP_CLRA: eMain = 8'h00;
      csw_pkg::OP_RL: eMain = {eMain[6:0], eMain[7]};
      csw_pkg::OP_RLC: {eCar, eMain} = {eMain, eCar};
      csw_pkg::OP_RR: eMain = {eMain[0], eMain[7:1]};
      csw_pkg::OP_RRC: {eMain, eCar} = {eCar, eMain};
      csw_pkg::OP_SWAP: eMain = {eMain[3:0], eMain[7:4]};
      csw_pkg::OP_SETBC: eCar = 1'b1;
      csw_pkg::OP_CLRC: eCar = 1'b0;
      csw_pkg::OP_CPLC: eCar = !eCar;
      csw_pkg::OP_SETBIT: eRes[k] = 1'b1;
      csw_pkg::OP_CLRBIT: eRes[k] = 1'b0;
      csw_pkg::OP_CPLBIT: eRes[k] = !bt;
      csw_pkg::OP_JNB: eTk = !bt;
      csw_pkg::OP_JBC: {eTk, eRes[k]} = {bt, 1'b0};
      csw_pkg::OP_MOVCB: eCar = bt;
      csw_pkg::OP_MOVBC: eRes[k] = eCar;
      csw_pkg::OP_ANLCB: eCar = eCar & bt;
      csw_pkg::OP_ORLCB: eCar = eCar | bt;
      default: ;
    endcase
    if (c <= csw_pkg::OP_SWAP)
      eRes = eMain;
  endfunction : model
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Strobes {write, read, bit write, op} held for exactly one edge
  task automatic go(input logic [3:0] s);
    {sfrWrEn, sfrRdEn, bitWrEn, opValid} = s;
    @(posedge clk);
    #1;
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWrData = d;
    go(4'h8);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    sfrAddr = a;
    go(4'h4);
    chk(sfrRdData, exp);
  endtask : rdchk
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Main sequence: reset values, register port, bit port, external port, operations
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    rdchk(csw_pkg::ADDR_MAIN, 8'h00);
    rdchk(csw_pkg::ADDR_AUX, 8'h00);
    rdchk(csw_pkg::ADDR_STATUS, 8'h00);
    v = rnd();
    w = rnd();
    wr(csw_pkg::ADDR_MAIN, v);
    wr(csw_pkg::ADDR_STATUS, w);
    rdchk(csw_pkg::ADDR_STATUS, {w[7:1], ^v});
    wr(csw_pkg::ADDR_AUX, w);
    chk(extWrEn, 1'b0);
    rdchk(csw_pkg::ADDR_AUX, w);
    for (int i = 0; i < 4; i++)
    begin
      wr(csw_pkg::ADDR_STATUS, 8'(i * 8));
      chk(bankBase, i * 8);
    end
    // Bit writes: read shows the old bit at the write edge, the new one after
    for (int j = 0; j < 2; j++)
    begin
      v = rnd();
      wr(j ? csw_pkg::ADDR_AUX : csw_pkg::ADDR_MAIN, v);
      for (int i = 0; i < 8; i++)
      begin
        bitAddr = (j ? csw_pkg::ADDR_AUX : csw_pkg::ADDR_MAIN) + 8'(i);
        bitWrData = !v[i];
        go(4'h2);
        chk(bitRdData, v[i]);
        go(4'h0);
        chk(bitRdData, !v[i]);
      end
      w = ~v;
      chk(j ? auxOperand : mainOperand, w);
    end
    // Foreign address goes out combinationally, read data comes back next edge
    v = rnd();
    w = rnd();
    sfrAddr = 8'h88;
    sfrWrData = v;
    extRdData = w;
    sfrWrEn = 1'b1;
    #1;
    chk({extWrEn, extAddr, extWrData}, {1'b1, 8'h88, v});
    // Let the foreign write land so the next strobe keeps the usual offset
    @(posedge clk);
    #1;
    go(4'h4);
    chk({extRdEn, sfrRdData}, {1'b1, w});
    // Operation and register write on the same register in one edge: operation wins
    sfrAddr = csw_pkg::ADDR_MAIN;
    sfrWrData = 8'h5a;
    opCode = csw_pkg::OP_CLRA;
    go(4'h9);
    chk(mainOperand, 8'h00);
    // Every code once, then random codes, often chained back to back
    for (int n = 0; n < 200; n++)
    begin
      v = rnd();
      w = rnd();
      op = csw_pkg::csw_op_t'((n < 32) ? n[4:0] : v[4:0]);
      if (n < 40 || w[0] || op == csw_pkg::OP_DA)
      begin
        eMain = rnd();
        eAux = (n == 7) ? 8'h00 : rnd();
        eCar = w[1];
        wr(csw_pkg::ADDR_MAIN, eMain);
        wr(csw_pkg::ADDR_AUX, eAux);
        wr(csw_pkg::ADDR_STATUS, {eCar, 7'h00});
      end
      opCode = op;
      opData = rnd();
      opBit = w[4:2];
      go(4'h1);
      model(op, opData, opBit);
      chk({opTaken, statusWord[7], statusWord[0], auxOperand, mainOperand},
        {eTk, eCar, ^eMain, eAux, eMain});
      if (eResV)
        chk(opResult, eRes);
    end
    // Reset in mid-run clears the registers again
    rst = 1'b1;
    go(4'h0);
    rst = 1'b0;
    chk({mainOperand, auxOperand, statusWord}, 24'h0);
    go(4'h0);
    end_of_test();
  end
endmodule : cpu_alu_status_word_test
`default_nettype wire
